// [shared/fxu_regs.svh]
`ifndef FXU_REGS_SVH
`define FXU_REGS_SVH

// Instruction field values and 32-bit operand constants
`define PRIMARY_OPCODE   6'h1f
`define XO_NABS          9'h1e8
`define XO_NEG           9'h068
`define XO_NAND          10'h1dc
`define MOST_NEGATIVE    32'h8000_0000
`define ONE_WORD         32'h0000_0001

// Register byte offsets on the bus
`define OFS_CTRL         8'h00
`define OFS_XER          8'h04
`define OFS_CR0          8'h08
`define OFS_RESULT       8'h0c
`define OFS_IRQ_STATUS   8'h10
`define OFS_IRQ_MASK     8'h14
`define OFS_COUNT        8'h18

// Field positions
`define CTRL_LEGACY_BIT  0
`define XER_SO_BIT       31
`define XER_OV_BIT       30
`define XER_CA_BIT       29
`define IRQ_DONE_BIT     0
`define IRQ_OVF_BIT      1
`define IRQ_ILLEGAL_BIT  2

// Reset values
`define CTRL_RESET       32'h0000_0001
`define MASK_RESET       3'h0

`endif

// [shared/fxu_pkg.sv]
package fxu_pkg;

	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_NABS = 2'b01,
		OP_NAND = 2'b10,
		OP_NEG  = 2'b11
	} op_e;

	typedef struct packed {
		logic so;
		logic signedWrapFlag;
		logic adderCoutBit;
	} xer_s;

	typedef struct packed {
		logic belowZeroFlag;
		logic aboveZeroFlag;
		logic zeroResultFlag;
		logic so;
	} cr0_s;

	typedef struct packed {
		logic [5:0] primary;
		logic [4:0] destRegField;
		logic [4:0] srcAField;
		logic [4:0] srcBField;
		logic       overflowEnable;
		logic [8:0] extOpcode;
		logic       recordFlag;
	} insn_s;

endpackage

// [src/fixed_point_negate_nand_unit.sv]
// How it works
// RULE_01: Negative absolute: primary 31, extended 488, overflow enable bit 21, record bit 31.
// RULE_02: Negative absolute writes minus the absolute value of the source.
// RULE_03: Four variants; overflow enable gates exception flags, record gates condition field.
// RULE_04: Negative absolute never alters the carry bit.
// RULE_05: Negative absolute with overflow enable clears overflow, keeps summary overflow.
// RULE_06: Negative absolute with record updates less, greater, zero, summary bits.
// RULE_07: Negative absolute accepted only while the legacy mode bit is set.
// RULE_08: NAND: primary 31, extended 476 in bits 21-30, record bit 31.
// RULE_09: NAND writes the inverted bitwise AND of both sources.
// RULE_10: NAND never touches any exception register bit.
// RULE_11: NAND with record updates condition field 0, otherwise leaves it.
// RULE_12: Negate: primary 31, extended 104, overflow enable bit 21, record bit 31.
// RULE_13: Negate writes the source with its sign reversed.
// RULE_14: Negate inverts and adds one; most-negative source overflows when enabled.
// RULE_15: Negate keeps carry; overflow enable updates summary and overflow flags.
// RULE_16: Recorded field compares result signed against zero, copies summary overflow.
// RULE_17: 32-bit operands; result and all flags commit together at completion.
// RULE_18: Core supplies operands with the word and accepts the write-back outputs.
`timescale 1ns/1ps
`include "fxu_regs.svh"
`default_nettype none

module fixed_point_negate_nand_unit (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Issue from the core
	input  wire logic        issueValid,
	input  wire logic [31:0] insnWord,
	input  wire logic [31:0] srcValA,
	input  wire logic [31:0] srcValS,
	input  wire logic [31:0] srcValB,
	// Write-back to the core
	output logic             doneValid,
	output logic             illegalInsn,
	output logic             gprWriteEn,
	output logic [4:0]       gprWriteIdx,
	output logic [31:0]      gprWriteData,
	output logic             xerWriteEn,
	output fxu_pkg::xer_s    xerOut,
	output logic             cr0WriteEn,
	output fxu_pkg::cr0_s    cr0Out,
	// Wishbone slave
	input  wire logic        wbCyc,
	input  wire logic        wbStb,
	input  wire logic        wbWe,
	input  wire logic [7:0]  wbAdr,
	input  wire logic [3:0]  wbSel,
	input  wire logic [31:0] wbDatIn,
	output logic [31:0]      wbDatOut,
	output logic             wbAck,
	// Interrupt
	output logic             irq
);

////////////////////////////////////////////////////////////////////////////////
// Decode

	fxu_pkg::insn_s insn;
	fxu_pkg::op_e   opSel;
	wire logic      primaryHit;
	wire logic      nabsHit;
	wire logic      negHit;
	wire logic      nandHit;
	wire logic      legacyMode;
	wire logic      recordOn;
	wire logic      overflowOn;

	logic [31:0]    ctrlReg;

	// Field numbering counts from the word's most significant bit, so
	// field bit 0 is insnWord[31] and the record flag is insnWord[0].
	// Reserved bits of the single-source forms are ignored, not refused,
	// so older code with stray bits there still runs.

	assign insn       = fxu_pkg::insn_s'(insnWord);
	assign primaryHit = insn.primary == `PRIMARY_OPCODE;                           // [RULE_01] [RULE_08] [RULE_12]
	assign nabsHit    = primaryHit && (insn.extOpcode == `XO_NABS);                // [RULE_01]
	assign negHit     = primaryHit && (insn.extOpcode == `XO_NEG);                 // [RULE_12]
	assign nandHit    = primaryHit && (insnWord[10:1] == `XO_NAND);                // [RULE_08]
	assign legacyMode = ctrlReg[`CTRL_LEGACY_BIT];
	assign recordOn   = insn.recordFlag;
	// NAND has no overflow enable; bit 21 belongs to its extended opcode
	assign overflowOn = insn.overflowEnable && (opSel != fxu_pkg::OP_NAND);        // [RULE_08] [RULE_03]

	// Outside legacy mode the negative absolute code decodes as illegal
	assign opSel = (nabsHit && legacyMode) ? fxu_pkg::OP_NABS :                    // [RULE_07]
		negHit  ? fxu_pkg::OP_NEG  :
		nandHit ? fxu_pkg::OP_NAND :
		fxu_pkg::OP_NONE;

////////////////////////////////////////////////////////////////////////////////
// Execute

	logic [31:0]    execResult;
	logic [4:0]     execDest;
	wire logic      negOverflow;
	wire logic [31:0] negValue;
	wire logic [31:0] nabsValue;
	wire logic [31:0] nandValue;

	fxu_pkg::xer_s  xerReg;
	fxu_pkg::xer_s  xerNext;
	fxu_pkg::xer_s  xerExec;
	fxu_pkg::cr0_s  cr0Reg;
	fxu_pkg::cr0_s  cr0Next;
	fxu_pkg::cr0_s  cr0Exec;

	// One adder serves negate and negative absolute alike; the most
	// negative value maps onto itself, which is the only overflow case.

	assign negValue    = 32'(~srcValA + `ONE_WORD);                                // [RULE_13] [RULE_14]
	assign nabsValue   = srcValA[31] ? srcValA : negValue;                         // [RULE_02]
	assign nandValue   = ~(srcValS & srcValB);                                     // [RULE_09]
	assign negOverflow = srcValA == `MOST_NEGATIVE;                                // [RULE_14]

	// NAND writes the register named by its second field, the others the first

	always_comb begin
		execResult = 32'h0000_0000;
		execDest   = insn.destRegField;
		unique case (opSel)
			fxu_pkg::OP_NABS: begin
				execResult = nabsValue;
			end
			fxu_pkg::OP_NEG: begin
				execResult = negValue;
			end
			fxu_pkg::OP_NAND: begin
				execResult = nandValue;
				execDest   = insn.srcAField;
			end
			fxu_pkg::OP_NONE: begin
				execResult = 32'h0000_0000;
			end
		endcase
	end

	// Carry is copied through on every path
	always_comb begin
		xerExec = xerReg;                                                          // [RULE_04] [RULE_10]
		unique case (opSel)
			fxu_pkg::OP_NABS: begin
				xerExec.signedWrapFlag = 1'b0;                                     // [RULE_05]
			end
			fxu_pkg::OP_NEG: begin
				xerExec.signedWrapFlag = negOverflow;                              // [RULE_15]
				xerExec.so             = xerReg.so | negOverflow;                  // [RULE_15]
			end
			fxu_pkg::OP_NAND, fxu_pkg::OP_NONE: begin
				xerExec = xerReg;
			end
		endcase
	end

	// Summary overflow seen by the condition field is the value after
	// this instruction's own exception update, not the stale one

	wire logic      soForCr0;
	assign soForCr0 = overflowOn ? xerExec.so : xerReg.so;

	always_comb begin
		cr0Exec.belowZeroFlag  = execResult[31];                                   // [RULE_16]
		cr0Exec.aboveZeroFlag  = !execResult[31] && (execResult != 32'h0000_0000); // [RULE_16]
		cr0Exec.zeroResultFlag = execResult == 32'h0000_0000;                      // [RULE_16]
		cr0Exec.so             = soForCr0;                                         // [RULE_16]
	end

	wire logic      commit;
	wire logic      xerUpdate;
	wire logic      cr0Update;
	wire logic      illegalNow;
	wire logic      ovfEvent;

	// Illegal words still answer within one cycle, so the core never
	// stalls waiting on this unit

	assign commit     = issueValid && (opSel != fxu_pkg::OP_NONE);                 // [RULE_18]
	assign illegalNow = issueValid && (opSel == fxu_pkg::OP_NONE);                 // [RULE_07]
	assign xerUpdate  = commit && overflowOn;                                      // [RULE_03] [RULE_10]
	assign cr0Update  = commit && recordOn;                                        // [RULE_06] [RULE_11] [RULE_15]
	assign ovfEvent   = xerUpdate && (opSel == fxu_pkg::OP_NEG) && negOverflow;

////////////////////////////////////////////////////////////////////////////////
// Bus decode

	logic [2:0]     irqStatusReg;
	logic [2:0]     irqStatusNext;
	logic [2:0]     irqMaskReg;
	logic [31:0]    resultReg;
	logic [31:0]    countReg;
	logic [31:0]    readMux;

	wire logic      busReq;
	wire logic      busWrite;
	wire logic [31:0] laneMask;
	wire logic      selCtrl;
	wire logic      selXer;
	wire logic      selCr0;
	wire logic      selStatus;
	wire logic      selMask;
	wire logic [31:0] xerWord;
	wire logic [31:0] xerWritten;
	wire logic [31:0] ctrlWritten;
	wire logic [31:0] cr0Written;
	wire logic [31:0] statusClear;
	wire logic [31:0] maskWritten;
	wire logic [2:0]  irqEvents;

	// Every access is answered one cycle after it is seen; no wait states
	// are ever inserted, but a master should still wait for ack

	assign busReq    = wbCyc && wbStb;
	// A write lands only at the edge where ack is seen high
	assign busWrite  = busReq && wbWe && wbAck;
	assign laneMask  = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
	assign selCtrl   = wbAdr == `OFS_CTRL;
	assign selXer    = wbAdr == `OFS_XER;
	assign selCr0    = wbAdr == `OFS_CR0;
	assign selStatus = wbAdr == `OFS_IRQ_STATUS;
	assign selMask   = wbAdr == `OFS_IRQ_MASK;

	assign xerWord   = {xerReg, 29'h000_0000};
	assign xerWritten  = (xerWord & ~laneMask) | (wbDatIn & laneMask);
	assign ctrlWritten = (ctrlReg & ~laneMask) | (wbDatIn & laneMask);
	assign cr0Written  = ({28'h000_0000, cr0Reg} & ~laneMask) | (wbDatIn & laneMask);
	assign maskWritten = ({29'h000_0000, irqMaskReg} & ~laneMask) | (wbDatIn & laneMask);
	assign statusClear = (busWrite && selStatus) ? (wbDatIn & laneMask) : 32'h0000_0000;

	// Unmapped offsets read as zero and ignore writes
	always_comb begin
		unique case (wbAdr)
			`OFS_CTRL:       readMux = {31'h000_0000, ctrlReg[`CTRL_LEGACY_BIT]};
			`OFS_XER:        readMux = xerWord;
			`OFS_CR0:        readMux = {28'h000_0000, cr0Reg};
			`OFS_RESULT:     readMux = resultReg;
			`OFS_IRQ_STATUS: readMux = {29'h000_0000, irqStatusReg};
			`OFS_IRQ_MASK:   readMux = {29'h000_0000, irqMaskReg};
			`OFS_COUNT:      readMux = countReg;
			default:         readMux = 32'h0000_0000;
		endcase
	end

////////////////////////////////////////////////////////////////////////////////
// Architectural state next values

	// Bus writes to undefined bits are dropped, except in the control register, which keeps all 32 bits but reads back only bit 0

	// An instruction retiring in the same cycle beats a software write
	assign xerNext = xerUpdate ? xerExec :                                         // [RULE_17]
		(busWrite && selXer) ? fxu_pkg::xer_s'(xerWritten[31:29]) : xerReg;
	assign cr0Next = cr0Update ? cr0Exec :                                         // [RULE_17]
		(busWrite && selCr0) ? fxu_pkg::cr0_s'(cr0Written[3:0]) : cr0Reg;

	// New events win over a clear arriving in the same cycle
	assign irqEvents     = {illegalNow, ovfEvent, commit};
	assign irqStatusNext = (irqStatusReg & ~statusClear[2:0]) | irqEvents;

////////////////////////////////////////////////////////////////////////////////
// Registers

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wbAck    <= 1'b0;
			wbDatOut <= 32'h0000_0000;
		end else begin
			wbAck    <= busReq && !wbAck;
			wbDatOut <= (busReq && !wbAck) ? readMux : 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrlReg    <= `CTRL_RESET;
			irqMaskReg <= `MASK_RESET;
		end else begin
			if (busWrite && selCtrl) begin
				ctrlReg <= ctrlWritten;
			end
			if (busWrite && selMask) begin
				irqMaskReg <= maskWritten[2:0];
			end
		end
	end

	// The interrupt follows the updated status, so a new event raises it
	// at the same edge as its status bit; a mask change acts one cycle later

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			xerReg       <= '0;
			cr0Reg       <= '0;
			irqStatusReg <= 3'h0;
			irq          <= 1'b0;
		end else begin
			xerReg       <= xerNext;
			cr0Reg       <= cr0Next;
			irqStatusReg <= irqStatusNext;
			irq          <= |(irqStatusNext & irqMaskReg);
		end
	end

	// Everything one instruction changes is presented in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			doneValid    <= 1'b0;
			illegalInsn  <= 1'b0;
			gprWriteEn   <= 1'b0;
			gprWriteIdx  <= 5'h00;
			gprWriteData <= 32'h0000_0000;
			xerWriteEn   <= 1'b0;
			cr0WriteEn   <= 1'b0;
		end else begin
			doneValid    <= commit;                                                // [RULE_17]
			illegalInsn  <= illegalNow;
			gprWriteEn   <= commit;                                                // [RULE_17]
			gprWriteIdx  <= commit ? execDest : 5'h00;
			gprWriteData <= commit ? execResult : 32'h0000_0000;
			xerWriteEn   <= xerUpdate;                                             // [RULE_03]
			cr0WriteEn   <= cr0Update;                                             // [RULE_03]
		end
	end

	// The completion count wraps silently; software reads it as a free
	// running tally and takes differences

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			xerOut    <= '0;
			cr0Out    <= '0;
			resultReg <= 32'h0000_0000;
			countReg  <= 32'h0000_0000;
		end else begin
			xerOut <= xerNext;
			cr0Out <= cr0Next;
			if (commit) begin
				resultReg <= execResult;
				countReg  <= 32'(countReg + `ONE_WORD);
			end
		end
	end

endmodule

`default_nettype wire

// [verif/core_issue_model.sv]
`timescale 1ns/1ps
`default_nettype none

module core_issue_model (
	// Clock
	input  wire logic        sys_clk,
	// Issue side
	input  wire logic [31:0] insnWord,
	output logic      [31:0] srcValA,
	output logic      [31:0] srcValS,
	output logic      [31:0] srcValB,
	// Write-back side
	input  wire logic        gprWriteEn,
	input  wire logic [4:0]  gprWriteIdx,
	input  wire logic [31:0] gprWriteData
);
	// Plain always: the bench also preloads entries between instructions
	logic [31:0] gpr [32];

	assign srcValA = gpr[insnWord[20:16]];
	assign srcValS = gpr[insnWord[25:21]];
	assign srcValB = gpr[insnWord[15:11]];

	always @(posedge sys_clk) begin
		if (gprWriteEn) begin
			gpr[gprWriteIdx] <= gprWriteData;
		end
	end
endmodule

`default_nettype wire

// [verif/fixed_point_negate_nand_unit_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fxu_regs.svh"

module fixed_point_negate_nand_unit_chk (
	// Clock and reset
	input wire logic          sys_clk,
	input wire logic          rst,
	// Issue
	input wire logic          issueValid,
	input wire logic [31:0]   insnWord,
	input wire logic [31:0]   srcValA,
	input wire logic [31:0]   srcValS,
	input wire logic [31:0]   srcValB,
	// Write-back
	input wire logic          doneValid,
	input wire logic          illegalInsn,
	input wire logic [31:0]   gprWriteData,
	input wire logic          xerWriteEn,
	input wire fxu_pkg::xer_s xerOut,
	input wire logic          cr0WriteEn,
	input wire fxu_pkg::cr0_s cr0Out,
	// Bus
	input wire logic          wbCyc,
	input wire logic          wbStb,
	input wire logic          wbAck
);
	wire prim   = insnWord[31:26] == `PRIMARY_OPCODE;
	wire isNeg  = prim && insnWord[9:1] == `XO_NEG;
	wire isNabs = prim && insnWord[9:1] == `XO_NABS;
	wire isNand = prim && insnWord[10:1] == `XO_NAND;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_nabs_oe;
		issueValid && isNabs && insnWord[10];
	endsequence
	sequence s_ack_pulse;
		wbAck ##1 !wbAck;
	endsequence

	////////////////////////////////////////////////////////////////
	a_one_answer: assert property (issueValid |=> doneValid ^ illegalInsn)
		else $error("issue not answered next cycle");
	a_no_stray: assert property (!issueValid |=> !doneValid && !illegalInsn)
		else $error("answer without issue");
	a_neg_value: assert property (issueValid && isNeg |=> gprWriteData == ~$past(srcValA) + `ONE_WORD)
		else $error("negate result wrong");
	a_nabs_value: assert property (issueValid && isNabs |=> illegalInsn
		|| gprWriteData == ($past(srcValA[31]) ? $past(srcValA) : ~$past(srcValA) + `ONE_WORD))
		else $error("negative absolute result wrong");
	a_nand_value: assert property (issueValid && isNand |=> gprWriteData == ~($past(srcValS) & $past(srcValB)))
		else $error("nand result wrong");
	a_nand_xer: assert property (issueValid && isNand |=> !xerWriteEn && $stable(xerOut))
		else $error("nand touched exception reg");
	a_nabs_ov: assert property (s_nabs_oe |=> illegalInsn
		|| (!xerOut.signedWrapFlag && xerOut.so == $past(xerOut.so)))
		else $error("nabs overflow handling wrong");
	a_neg_ov: assert property (issueValid && isNeg && insnWord[10]
		|=> xerOut.signedWrapFlag == ($past(srcValA) == `MOST_NEGATIVE))
		else $error("negate overflow wrong");
	a_carry_kept: assert property (issueValid |=> $stable(xerOut.adderCoutBit))
		else $error("carry changed");
	a_record_gate: assert property (issueValid |=> cr0WriteEn == (doneValid && $past(insnWord[0])))
		else $error("condition field gate wrong");
	a_oe_gate: assert property (issueValid |=> xerWriteEn == (doneValid && $past(insnWord[10]) && !$past(isNand)))
		else $error("exception gate wrong");
	a_cr0_sign: assert property (cr0WriteEn |-> cr0Out.belowZeroFlag == gprWriteData[31] && cr0Out.so == xerOut.so
		&& cr0Out.zeroResultFlag == (gprWriteData == 32'h0000_0000))
		else $error("condition field value wrong");
	a_bus_ack: assert property (wbCyc && wbStb && !wbAck |=> s_ack_pulse)
		else $error("bus ack not a one cycle pulse");
endmodule

bind fixed_point_negate_nand_unit fixed_point_negate_nand_unit_chk i_chk (.sys_clk, .rst, .issueValid, .insnWord,
	.srcValA, .srcValS, .srcValB, .doneValid, .illegalInsn, .gprWriteData, .xerWriteEn, .xerOut, .cr0WriteEn,
	.cr0Out, .wbCyc, .wbStb, .wbAck);

`default_nettype wire

// [verif/fixed_point_negate_nand_unit_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module fixed_point_negate_nand_unit_bench;
	logic          sys_clk = 1'b0;
	logic          rst = 1'b1;
	logic          issueValid = 1'b0;
	logic [31:0]   insnWord = 32'h0000_0000;
	logic [31:0]   srcValA, srcValS, srcValB, gprWriteData, wbDatOut;
	logic          doneValid, illegalInsn, gprWriteEn, xerWriteEn, cr0WriteEn, wbAck, irq;
	logic [4:0]    gprWriteIdx;
	fxu_pkg::xer_s xerOut;
	fxu_pkg::cr0_s cr0Out;
	logic          wbCyc = 1'b0;
	logic          wbStb = 1'b0;
	logic          wbWe = 1'b0;
	logic [7:0]    wbAdr = 8'h00;
	logic [3:0]    wbSel = 4'hf;
	logic [31:0]   wbDatIn = 32'h0000_0000;
	int            fails = 0;
	int            n_compared = 0;

	always #20 sys_clk = ~sys_clk;

	fixed_point_negate_nand_unit i_dut (.sys_clk, .rst, .issueValid, .insnWord, .srcValA, .srcValS, .srcValB,
		.doneValid, .illegalInsn, .gprWriteEn, .gprWriteIdx, .gprWriteData, .xerWriteEn, .xerOut, .cr0WriteEn,
		.cr0Out, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatIn, .wbDatOut, .wbAck, .irq);
	core_issue_model i_core (.sys_clk, .insnWord, .srcValA, .srcValS, .srcValB, .gprWriteEn, .gprWriteIdx,
		.gprWriteData);

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDatIn <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		q = wbDatOut;
		if (n == 20) fails++;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask

	// Flags f: done, illegal, record enable, {so,ov,ca}, {lt,gt,eq,so}; dest is register 6 for all forms
	task automatic run(input logic [9:0] xo, input logic rc, input logic [31:0] x, y, d, input logic [9:0] f);
		@(posedge sys_clk);
		i_core.gpr[4] <= x;
		i_core.gpr[7] <= y;
		issueValid <= 1'b1;
		insnWord <= (xo == 10'h1dc) ? {6'h1f, 5'h4, 5'h6, 5'h7, xo, rc} : {6'h1f, 5'h6, 5'h4, 5'h0, xo, rc};
		@(posedge sys_clk);
		issueValid <= 1'b0;
		#1;
		chk(gprWriteData, d);
		chk({16'h0000, gprWriteEn, gprWriteIdx, doneValid, illegalInsn, cr0WriteEn, xerOut, cr0Out},
			{16'h0000, f[9], (f[9] ? 5'h6 : 5'h0), f});
	endtask

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h00, 32'h0000_0001);
		rd(8'h04, 32'h0000_0000);
		rd(8'h08, 32'h0000_0000);
		rd(8'h14, 32'h0000_0000);
		rd(8'h18, 32'h0000_0000);
		$display("test reset_values done");
		// Carry preset so that any stray write to it shows
		wr(8'h04, 32'h2000_0000);
		run(10'h068, 1'b0, 32'h9000_3000, 32'h0000_0000, 32'h6fff_d000, 10'h210);
		run(10'h068, 1'b1, 32'h789a_789b, 32'h0000_0000, 32'h8765_8765, 10'h298);
		run(10'h268, 1'b0, 32'h8000_0000, 32'h0000_0000, 32'h8000_0000, 10'h278);
		run(10'h3e8, 1'b1, 32'h8000_0000, 32'h0000_0000, 32'h8000_0000, 10'h2d9);
		run(10'h268, 1'b1, 32'h0000_0005, 32'h0000_0000, 32'hffff_fffb, 10'h2d9);
		run(10'h1e8, 1'b0, 32'h0000_3000, 32'h0000_0000, 32'hffff_d000, 10'h259);
		run(10'h1e8, 1'b1, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 10'h2d3);
		run(10'h3e8, 1'b0, 32'h0000_0001, 32'h0000_0000, 32'hffff_ffff, 10'h253);
		run(10'h1dc, 1'b0, 32'h9000_3000, 32'h789a_789b, 32'hefff_cfff, 10'h253);
		run(10'h1dc, 1'b1, 32'hb004_3000, 32'h789a_789b, 32'hcfff_cfff, 10'h2d9);
		run(10'h1dc, 1'b1, 32'h8000_0000, 32'hffff_ffff, 32'h7fff_ffff, 10'h2d5);
		$display("test operations done");
		wr(8'h00, 32'h0000_0000);
		run(10'h1e8, 1'b1, 32'h0000_3000, 32'h0000_0000, 32'h0000_0000, 10'h155);
		run(10'h000, 1'b1, 32'h0000_3000, 32'h0000_0000, 32'h0000_0000, 10'h155);
		rd(8'h18, 32'h0000_000b);
		rd(8'h1c, 32'h0000_0000);
		$display("test refusals done");
		rd(8'h10, 32'h0000_0007);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		wr(8'h14, 32'h0000_0004);
		repeat (2) @(posedge sys_clk);
		#1;
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		wr(8'h10, 32'h0000_0004);
		repeat (2) @(posedge sys_clk);
		#1;
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		rd(8'h10, 32'h0000_0003);
		$display("test interrupts done");
		tally_and_finish();
	end

	initial begin
		repeat (3000) @(posedge sys_clk);
		fails++;
		tally_and_finish();
	end
endmodule

`default_nettype wire
